// File: rtl/fpc_defines.vh
// Offsets, field positions, reset values and timing for the counter bank
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH

// Per-counter window: counter k at byte k*0x20, registers below
`define FPC_CNT_STRIDE   8'h20
`define FPC_R_CTRL       3'h0
`define FPC_R_HFN        3'h1
`define FPC_R_UPPER      3'h2
`define FPC_R_LOWER      3'h3
`define FPC_R_ACC        3'h4
`define FPC_R_OMB        3'h5
`define FPC_R_STAT       3'h6

// Global window at block index 6, file table at block index 7
`define FPC_BLK_GLOBAL   3'h6
`define FPC_BLK_FILES    3'h7
`define FPC_R_INT_STAT   3'h0
`define FPC_R_INT_MASK   3'h1
`define FPC_R_RUN        3'h2
`define FPC_R_PROG_OUT   3'h3
`define FPC_R_OUT_STATE  3'h4

// Control register fields
`define FPC_CTRL_AUTO    0
`define FPC_CTRL_CE      1
`define FPC_CTRL_START   2
`define FPC_CTRL_MODE_LO 4
`define FPC_CTRL_MODE_HI 6

// Status register fields
`define FPC_STAT_ERR_HI  7
`define FPC_STAT_CAUSE_LO 8
`define FPC_STAT_ACTIVE  12

// Reset values
`define FPC_CTRL_RST     8'h00
`define FPC_HFN_RST      16'h0000
`define FPC_UPPER_RST    32'h7FFFFFFF
`define FPC_LOWER_RST    32'h80000001

// Count limits and codes
`define FPC_ACC_MAX      32'h7FFFFFFF
`define FPC_ACC_MIN      32'h80000001
`define FPC_HFN_LO       16'h0003
`define FPC_HFN_HI       16'h00FF
`define FPC_ERR_BADFILE  8'h01

// Modes: bits 2:1 pick the input function, bit 0 adds reset/hold
`define FPC_MODE_UP      2'h0
`define FPC_MODE_PDIR    2'h1
`define FPC_MODE_UPDN    2'h2
`define FPC_MODE_QUAD    2'h3

// Timing: highest input rate and the clock it is sampled with
`define FPC_MAX_RATE_KHZ 32'h00000064
`define FPC_CLK_KHZ      32'h0001E848
`define FPC_MIN_PERIOD_CYC (`FPC_CLK_KHZ / `FPC_MAX_RATE_KHZ)

`endif

// File: rtl/fpc_step.v
// Per-counter input decoder: turns two phase inputs into count steps
`timescale 1ns/1ns
`include "fpc_defines.vh"

module fpc_step (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       phase_a,
  input  wire       phase_b,
  input  wire [1:0] func,
  output reg        step_up,
  output reg        step_dn
);

  reg prev_a_ff;
  reg prev_b_ff;
  wire rise_a;
  wire rise_b;
  wire moved;

  // Previous input levels for edge and transition detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_a_ff <= 1'b0;
      prev_b_ff <= 1'b0;
    end else begin
      prev_a_ff <= phase_a;
      prev_b_ff <= phase_b;
    end
  end

  assign rise_a = phase_a & ~prev_a_ff;
  assign rise_b = phase_b & ~prev_b_ff;
  // Exactly one phase changed; a double change is a lost step
  assign moved  = (phase_a ^ prev_a_ff) ^ (phase_b ^ prev_b_ff);

  // Input function chosen by the mode
  always @* begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (func)
      `FPC_MODE_UP: begin
        step_up = rise_a;
      end
      `FPC_MODE_PDIR: begin
        step_up = rise_a & ~phase_b;
        step_dn = rise_a & phase_b;
      end
      `FPC_MODE_UPDN: begin
        step_up = rise_a;
        step_dn = rise_b;
      end
      `FPC_MODE_QUAD: begin
        step_up = moved & (phase_a ^ prev_b_ff);
        step_dn = moved & ~(phase_a ^ prev_b_ff);
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

endmodule // fpc_step

// File: rtl/fpc_bank.v
// Bank of six fast pulse counters with an APB register slave
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "fpc_defines.vh"

// Overview of operation
// - Six counters each take pulses up to 100 kHz: mains 0-2, subs 3-5.
// - Mains use inputs 4k..4k+3; subs 3,4,5 use inputs 2-3, 6-7, 10-11.
// - A sub is disabled when its main's mode takes their shared inputs.
// - Each count is a signed 32-bit value limited to +/-2147483647.
// - A count equal to a preset, or an overflow/underflow, interrupts.
// - The handler file number is valid only in 3..255 for a file present.
// - An invalid handler file number stops counting and shows error 1.
// - With auto-start set the counter runs as soon as run mode is entered.
// - The count-enable flag gates all accumulation.
// - In mode 0 the count clears to zero on reaching the upper preset.
// - The mode sets each input's function; mode 0 counts on input A.
// - Mode 6 makes the counter a quadrature counter for an encoder.
// - Outputs claimed by a counter's mask ignore program writes.
module fpc_bank #(
  parameter NOUT = 8
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata_ff,
  output reg             pready_ff,
  output reg             pslverr_ff,
  input  wire [11:0]     cnt_in,
  output reg  [NOUT-1:0] out_pins_ff,
  output reg             irq_ff
);

  localparam NCNT = 6;

  // Pin synchroniser stages
  reg  [11:0]     sync1_ff;
  reg  [11:0]     sync2_ff;

  // Per-counter configuration, count and last cause
  reg  [7:0]      ctrl_ff  [0:NCNT-1];
  reg  [15:0]     hfn_ff   [0:NCNT-1];
  reg  [31:0]     upper_ff [0:NCNT-1];
  reg  [31:0]     lower_ff [0:NCNT-1];
  reg  [31:0]     acc_ff   [0:NCNT-1];
  reg  [NOUT-1:0] omb_ff   [0:NCNT-1];
  reg  [3:0]      cause_ff [0:NCNT-1];

  // File-present table and global control
  reg  [31:0]     file_ff  [0:7];
  reg  [NCNT-1:0] zprev_ff;
  reg  [NCNT-1:0] int_stat_ff;
  reg  [NCNT-1:0] int_mask_ff;
  reg             run_ff;
  reg  [NOUT-1:0] prog_out_ff;

  // Decoder steps and per-counter qualification
  wire [NCNT-1:0] step_up;
  wire [NCNT-1:0] step_dn;
  reg  [NCNT-1:0] err_w;
  reg  [NCNT-1:0] active_w;
  reg  [NCNT-1:0] ev_any_w;
  reg  [32*NCNT-1:0] nxt_acc_w;
  reg  [4*NCNT-1:0]  nxt_cause_w;
  reg  [NCNT-1:0] nxt_int_stat;

  // Next pin levels and read path
  reg  [NOUT-1:0] nxt_out;
  reg  [31:0]     rdata_w;
  reg             unmapped_w;

  // Loop scratch; every process owns its loop index so none is shared between processes
  reg  [31:0]     tmp_acc;
  reg  [3:0]      tmp_ev;
  reg  [2:0]      tmp_mode;
  reg             tmp_run;
  reg             tmp_z;
  integer         k;
  integer         kr;
  integer         ko;

  // APB decode; the access phase is the cycle before ready
  wire [2:0] blk = paddr[7:5];
  wire [2:0] rsel = paddr[4:2];
  wire       acc_phase = psel & penable & ~pready_ff;
  wire       wr_en = psel & penable & pready_ff & pwrite;

  // Effective mode: subs have no reset/hold inputs, so bit 0 is dropped
  function [2:0] eff_mode;
    input [7:0] ctrl;
    input       is_sub;
    begin
      eff_mode = ctrl[`FPC_CTRL_MODE_HI:`FPC_CTRL_MODE_LO];
      if (is_sub)
        eff_mode[0] = 1'b0;
    end
  endfunction

  // Preset equality test kept in one place for both presets
  function hits;
    input [31:0] val;
    input [31:0] preset;
    begin
      hits = (val == preset);
    end
  endfunction

  // Global register write strobe, shared by every writable global register
  function glob_wr;
    input       en;
    input [2:0] b;
    input [2:0] r;
    input [2:0] want;
    begin
      glob_wr = en & (b == `FPC_BLK_GLOBAL) & (r == want);
    end
  endfunction

  // Two-flop synchronisers on the pulse inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 12'h000;
      sync2_ff <= 12'h000;
    end else begin
      sync1_ff <= cnt_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Input decoders; 125 MHz sampling covers 100 kHz easily
  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : dec
      localparam BASE = (g < 3) ? 4 * g : 4 * (g - 3) + 2;
      // Decoder function is mode bits 2:1
      wire [2:0] mode_g = eff_mode(ctrl_ff[g], g >= 3);
      fpc_step u_step (
        .pclk    (pclk),
        .presetn (presetn),
        .phase_a (sync2_ff[BASE]),
        .phase_b (sync2_ff[BASE+1]),
        .func    (mode_g[2:1]),
        .step_up (step_up[g]),
        .step_dn (step_dn[g])
      );
    end
  endgenerate

  // Qualification of each counter and its next count
  always @* begin
    tmp_acc = 32'h00000000;
    tmp_ev = 4'h0;
    tmp_mode = 3'h0;
    tmp_run = 1'b0;
    tmp_z = 1'b0;
    nxt_acc_w = {(32*NCNT){1'b0}};
    nxt_cause_w = {(4*NCNT){1'b0}};
    err_w = {NCNT{1'b0}};
    active_w = {NCNT{1'b0}};
    ev_any_w = {NCNT{1'b0}};
    for (k = 0; k < NCNT; k = k + 1) begin
      tmp_mode = eff_mode(ctrl_ff[k], k >= 3);
      err_w[k] = (hfn_ff[k] < `FPC_HFN_LO) | (hfn_ff[k] > `FPC_HFN_HI) |
                 ~file_ff[hfn_ff[k][7:5]][hfn_ff[k][4:0]];
      tmp_run = run_ff & (ctrl_ff[k][`FPC_CTRL_AUTO] |
                          ctrl_ff[k][`FPC_CTRL_START]);
      active_w[k] = tmp_run & ctrl_ff[k][`FPC_CTRL_CE] & ~err_w[k];
      if (k >= 3)
        active_w[k] = active_w[k] & ~ctrl_ff[k-3][`FPC_CTRL_MODE_LO];
      // Main in odd mode: input 4k+2 resets, input 4k+3 holds
      if (k < 3 && tmp_mode[0]) begin
        tmp_z = sync2_ff[4*k+2] & ~zprev_ff[k];
        if (sync2_ff[4*k+3])
          active_w[k] = 1'b0;
      end else begin
        tmp_z = 1'b0;
      end
      tmp_acc = acc_ff[k];
      tmp_ev = 4'h0;
      if (tmp_z && active_w[k]) begin
        tmp_acc = 32'h00000000;
      end else if (active_w[k] && step_up[k]) begin
        // overflow wraps to the low limit
        if (tmp_acc == `FPC_ACC_MAX) begin
          tmp_acc = `FPC_ACC_MIN;
          tmp_ev[2] = 1'b1;
        end else begin
          tmp_acc = tmp_acc + 32'h00000001;
        end
      end else if (active_w[k] && step_dn[k]) begin
        // underflow wraps to the high limit
        if (tmp_acc == `FPC_ACC_MIN) begin
          tmp_acc = `FPC_ACC_MAX;
          tmp_ev[3] = 1'b1;
        end else begin
          tmp_acc = tmp_acc - 32'h00000001;
        end
      end
      if (active_w[k] && (step_up[k] || step_dn[k]) && !tmp_ev[2] &&
          !tmp_ev[3]) begin
        tmp_ev[0] = hits(tmp_acc, upper_ff[k]);
        tmp_ev[1] = hits(tmp_acc, lower_ff[k]);
        // up counter clears at the upper preset
        if (tmp_ev[0] && tmp_mode[2:1] == `FPC_MODE_UP)
          tmp_acc = 32'h00000000;
      end
      nxt_acc_w[k*32 +: 32] = tmp_acc;
      nxt_cause_w[k*4 +: 4] = tmp_ev;
      ev_any_w[k] = |tmp_ev;
    end
  end

  // Status next value: write one clears, a same-cycle event wins
  always @* begin
    nxt_int_stat = int_stat_ff | ev_any_w;
    if (glob_wr(wr_en, blk, rsel, `FPC_R_INT_STAT))
      nxt_int_stat = (int_stat_ff & ~pwdata[NCNT-1:0]) | ev_any_w;
  end

  // Counts, configuration and software writes share one process for all arrays
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (kr = 0; kr < NCNT; kr = kr + 1) begin
        ctrl_ff[kr]  <= `FPC_CTRL_RST;
        hfn_ff[kr]   <= `FPC_HFN_RST;
        upper_ff[kr] <= `FPC_UPPER_RST;
        lower_ff[kr] <= `FPC_LOWER_RST;
        acc_ff[kr]   <= 32'h00000000;
        omb_ff[kr]   <= {NOUT{1'b0}};
        cause_ff[kr] <= 4'h0;
      end
      for (kr = 0; kr < 8; kr = kr + 1)
        file_ff[kr] <= 32'h00000000;
      zprev_ff    <= {NCNT{1'b0}};
      int_stat_ff <= {NCNT{1'b0}};
      int_mask_ff <= {NCNT{1'b0}};
      run_ff      <= 1'b0;
      prog_out_ff <= {NOUT{1'b0}};
    end else begin
      for (kr = 0; kr < NCNT; kr = kr + 1) begin
        zprev_ff[kr] <= (kr < 3) ? sync2_ff[4*kr+2] : 1'b0;
        acc_ff[kr] <= nxt_acc_w[kr*32 +: 32];
        if (ev_any_w[kr])
          cause_ff[kr] <= nxt_cause_w[kr*4 +: 4];
        // A software preload of the count beats a same-cycle step
        if (wr_en && blk == kr) begin
          case (rsel)
            `FPC_R_CTRL:  ctrl_ff[kr]  <= pwdata[7:0];
            `FPC_R_HFN:   hfn_ff[kr]   <= pwdata[15:0];
            `FPC_R_UPPER: upper_ff[kr] <= pwdata;
            `FPC_R_LOWER: lower_ff[kr] <= pwdata;
            `FPC_R_ACC:   acc_ff[kr]   <= pwdata;
            `FPC_R_OMB:   omb_ff[kr]   <= pwdata[NOUT-1:0];
            default: begin
            end
          endcase
        end
      end
      if (wr_en && blk == `FPC_BLK_FILES)
        file_ff[rsel] <= pwdata;
      if (glob_wr(wr_en, blk, rsel, `FPC_R_INT_MASK))
        int_mask_ff <= pwdata[NCNT-1:0];
      if (glob_wr(wr_en, blk, rsel, `FPC_R_RUN))
        run_ff <= pwdata[0];
      if (glob_wr(wr_en, blk, rsel, `FPC_R_PROG_OUT))
        prog_out_ff <= pwdata[NOUT-1:0];
      int_stat_ff <= nxt_int_stat;
    end
  end

  // Output ownership; lowest-numbered counter wins a shared bit
  always @* begin
    nxt_out = prog_out_ff;
    for (ko = NCNT - 1; ko >= 0; ko = ko - 1) begin
      nxt_out = (nxt_out & ~omb_ff[ko]) |
                (omb_ff[ko] & {NOUT{$signed(acc_ff[ko]) >=
                                    $signed(upper_ff[ko])}});
    end
  end

  // Read mux and unmapped detection
  always @* begin
    rdata_w = 32'h00000000;
    unmapped_w = 1'b0;
    if (blk < NCNT) begin
      case (rsel)
        `FPC_R_CTRL:  rdata_w = {24'h000000, ctrl_ff[blk]};
        `FPC_R_HFN:   rdata_w = {16'h0000, hfn_ff[blk]};
        `FPC_R_UPPER: rdata_w = upper_ff[blk];
        `FPC_R_LOWER: rdata_w = lower_ff[blk];
        `FPC_R_ACC:   rdata_w = acc_ff[blk];
        `FPC_R_OMB:   rdata_w[NOUT-1:0] = omb_ff[blk];
        `FPC_R_STAT: begin
          rdata_w[`FPC_STAT_ERR_HI:0] =
            err_w[blk] ? `FPC_ERR_BADFILE : 8'h00;
          rdata_w[`FPC_STAT_CAUSE_LO +: 4] = cause_ff[blk];
          rdata_w[`FPC_STAT_ACTIVE] = active_w[blk];
        end
        default: unmapped_w = 1'b1;
      endcase
    end else if (blk == `FPC_BLK_GLOBAL) begin
      case (rsel)
        `FPC_R_INT_STAT:  rdata_w[NCNT-1:0] = int_stat_ff;
        `FPC_R_INT_MASK:  rdata_w[NCNT-1:0] = int_mask_ff;
        `FPC_R_RUN:       rdata_w[0] = run_ff;
        `FPC_R_PROG_OUT:  rdata_w[NOUT-1:0] = prog_out_ff;
        `FPC_R_OUT_STATE: rdata_w[NOUT-1:0] = out_pins_ff;
        default: unmapped_w = 1'b1;
      endcase
    end else begin
      rdata_w = file_ff[rsel];
    end
  end

  // APB answer: one wait state so read data comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      prdata_ff   <= 32'h00000000;
      out_pins_ff <= {NOUT{1'b0}};
      irq_ff      <= 1'b0;
    end else begin
      pready_ff  <= acc_phase;
      pslverr_ff <= acc_phase & unmapped_w;
      if (acc_phase)
        prdata_ff <= pwrite ? 32'h00000000 : rdata_w;
      out_pins_ff <= nxt_out;
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

endmodule // fpc_bank

// File: bench/fpc_bank_sva.sv
// Port-level assertions for the counter bank, bound to its top
`timescale 1ns/1ns
module fpc_bank_sva #(
  parameter NOUT = 8
) (
  input logic            pclk,
  input logic            presetn,
  input logic            psel,
  input logic            penable,
  input logic            pwrite,
  input logic [7:0]      paddr,
  input logic [31:0]     pwdata,
  input logic [31:0]     prdata_ff,
  input logic            pready_ff,
  input logic            pslverr_ff,
  input logic [11:0]     cnt_in,
  input logic [NOUT-1:0] out_pins_ff,
  input logic            irq_ff
);
  logic [31:0] ctrl0_ff;
  logic [31:0] upper0_ff;
  logic [15:0] hfn0_ff;
  logic [31:0] mask_ff;
  wire         wr_done = psel && penable && pready_ff && pwrite;
  wire         rd_done = psel && penable && pready_ff && !pwrite;
  wire         acc_rd  = rd_done && paddr < 8'hC0 && paddr[4:2] == 3'h4;

  // Shadow of counter 0 setup and the interrupt mask, so a read knows what it may show
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff  <= 32'h0;
      upper0_ff <= 32'h7FFFFFFF;
      hfn0_ff   <= 16'h0;
      mask_ff   <= 32'h0;
    end else if (wr_done) begin
      case (paddr)
        8'h00: ctrl0_ff <= pwdata;
        8'h04: hfn0_ff <= pwdata[15:0];
        8'h08: upper0_ff <= pwdata;
        8'hC4: mask_ff <= pwdata;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access phase with one wait, then a one-cycle answer
  sequence s_wait;
    psel && penable && !pready_ff;
  endsequence
  sequence s_answer;
    pready_ff ##1 !pready_ff;
  endsequence

  a_one_wait_state: assert property (s_wait |=> s_answer)
    else $error("ready not one cycle after access");
  a_ready_in_access: assert property (pready_ff |-> psel && penable)
    else $error("ready outside an access");
  a_unmapped_err: assert property (
    (s_wait and (paddr < 8'hC0 && paddr[4:2] == 3'h7)) |=> pslverr_ff)
    else $error("hole in a counter window answered without error");
  a_err_reads_zero: assert property (
    pslverr_ff |-> pready_ff && prdata_ff == 32'h0)
    else $error("error answer malformed");
  a_write_data_zero: assert property (
    pready_ff && pwrite |-> prdata_ff == 32'h0)
    else $error("read data not zero on a write");
  a_acc_in_range: assert property (
    acc_rd |-> prdata_ff != 32'h80000000)
    else $error("count read outside signed range");
  a_up_mode_clears: assert property (
    acc_rd && paddr == 8'h10 && ctrl0_ff[6:5] == 2'h0
    |-> prdata_ff != upper0_ff)
    else $error("up count left standing at upper preset");
  a_bad_file_err: assert property (
    rd_done && paddr == 8'h18 && (hfn0_ff < 16'h3 || hfn0_ff > 16'hFF)
    |-> prdata_ff[7:0] == 8'h01)
    else $error("bad handler file without error code");
  a_irq_masked: assert property (
    irq_ff |-> $past(mask_ff) != 32'h0)
    else $error("interrupt high with all sources masked");
endmodule // fpc_bank_sva

bind fpc_bank fpc_bank_sva #(.NOUT(NOUT)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .cnt_in(cnt_in), .out_pins_ff(out_pins_ff), .irq_ff(irq_ff));

// File: bench/fpc_src.sv
// Pulse and encoder source that drives the counter inputs
`timescale 1ns/1ns
module fpc_src (
  input  logic        pclk,
  output logic [11:0] cnt_in
);
  initial cnt_in = 12'h000;

  // Each level stands three clocks, more than the two-flop sync needs
  task automatic hold(input logic [11:0] v);
    @(posedge pclk);
    cnt_in <= v;
    repeat (2) @(posedge pclk);
  endtask

  // Clean pulses on one input, which idles low
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      hold(cnt_in | (12'h001 << i));
      hold(cnt_in & ~(12'h001 << i));
    end
  endtask

  task automatic quad(input int b, input int n, input bit up);
    logic [1:0] ph [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    repeat (n)
      for (int s = 1; s <= 4; s++)
        hold((cnt_in & ~(12'h003 << b))
             | (12'(ph[up ? s % 4 : 4 - s]) << b));
  endtask
endmodule // fpc_src

// File: bench/tb.sv
// Self-checking bench for the counter bank
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata_ff;
  wire         pready_ff, pslverr_ff, irq_ff;
  wire  [7:0]  out_pins_ff;
  wire  [11:0] cnt_in;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] bad [3] = '{32'h2, 32'h100, 32'h4};

  fpc_bank #(.NOUT(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .cnt_in(cnt_in),
    .out_pins_ff(out_pins_ff), .irq_ff(irq_ff));
  fpc_src u_src (.pclk(pclk), .cnt_in(cnt_in));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the answer is kept in rdat and rerr
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1 && ++n < 20);
    chk("pready", 32'h1, 32'(pready_ff));
    rdat = prdata_ff;
    rerr = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    chk("pslverr", 32'h0, 32'(rerr));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h7FFFFFFF);
    rd(8'h0C, 32'h80000001);
    // Holes answer with an error
    xfer(8'h1C, 1'b0, 32'h0);
    chk("err 1C", 32'h1, 32'(rerr));
    xfer(8'hD8, 1'b1, 32'hFFFFFFFF);
    chk("err D8", 32'h1, 32'(rerr));
    // Counter 0 up mode, preset 5, file 3 present, auto-start
    wr(8'hE0, 32'h8);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h5);
    wr(8'hC4, 32'h1);
    wr(8'h00, 32'h3);
    u_src.pulse(0, 2);
    rd(8'h10, 32'h0);
    wr(8'hC8, 32'h1);
    u_src.pulse(0, 3);
    rd(8'h10, 32'h3);
    u_src.pulse(0, 2);
    rd(8'h10, 32'h0);
    xfer(8'h18, 1'b0, 32'h0);
    chk("upper cause", 32'h1, 32'(rdat[8]));
    rd(8'hC0, 32'h1);
    chk("irq", 32'h1, 32'(irq_ff));
    wr(8'hC0, 32'h1);
    rd(8'hC0, 32'h0);
    chk("irq", 32'h0, 32'(irq_ff));
    // Enable and start gate the count
    wr(8'h00, 32'h1);
    u_src.pulse(0, 2);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h2);
    u_src.pulse(0, 2);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h6);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h1);
    // Claimed pin follows the counter, not program writes
    wr(8'h14, 32'h1);
    wr(8'hCC, 32'hFF);
    rd(8'hD0, 32'hFE);
    chk("pins", 32'hFE, 32'(out_pins_ff));
    // Handler file out of range or absent halts counting
    foreach (bad[i]) begin
      wr(8'h04, bad[i]);
      u_src.pulse(0, 1);
      xfer(8'h18, 1'b0, 32'h0);
      chk("err code", 32'h1, {24'h0, rdat[7:0]});
      rd(8'h10, 32'h1);
    end
    wr(8'hFC, 32'h80000000);
    wr(8'h04, 32'hFF);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h2);
    // Encoder: four steps a cycle, each way
    wr(8'h08, 32'h64);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h63);
    u_src.quad(0, 2, 1'b1);
    rd(8'h10, 32'h8);
    u_src.quad(0, 1, 1'b0);
    rd(8'h10, 32'h4);
    // Sub 3 on inputs 2,3 yields them to an odd main mode
    wr(8'h64, 32'hFF);
    wr(8'h68, 32'h64);
    wr(8'h60, 32'h3);
    u_src.pulse(2, 2);
    rd(8'h70, 32'h2);
    rd(8'h10, 32'h4);
    wr(8'h00, 32'h13);
    u_src.pulse(2, 2);
    rd(8'h70, 32'h2);
    rd(8'h10, 32'h0);
    // Hold input stops a main in odd mode; pulse/dir counts down on A while B is high
    u_src.hold(12'h008);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h0);
    u_src.hold(12'h000);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h1);
    wr(8'h00, 32'h23);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h2);
    u_src.hold(12'h002);
    u_src.pulse(0, 1);
    u_src.hold(12'h000);
    rd(8'h10, 32'h1);
    // Remaining counters each on their own input
    for (int k = 1; k < 6; k++) begin
      if (k == 3) continue;
      wr(8'(k * 32 + 4), 32'h3);
      wr(8'(k * 32 + 8), 32'h64);
      wr(8'(k * 32), 32'h3);
      u_src.pulse(k < 3 ? 4 * k : 4 * k - 10, 1);
      rd(8'(k * 32 + 16), 32'h1);
    end
    // Wrap at the signed limits, up on A and down on B
    wr(8'h00, 32'h43);
    wr(8'h10, 32'h7FFFFFFF);
    wr(8'hC0, 32'h3F);
    u_src.pulse(0, 1);
    rd(8'h10, 32'h80000001);
    xfer(8'h18, 1'b0, 32'h0);
    chk("ovf cause", 32'h1, 32'(rdat[10]));
    u_src.pulse(1, 1);
    rd(8'h10, 32'h7FFFFFFF);
    xfer(8'h18, 1'b0, 32'h0);
    chk("unf cause", 32'h1, 32'(rdat[11]));
    // Interrupt masked, unmasked, then cleared
    rd(8'hC0, 32'h1);
    wr(8'hC4, 32'h0);
    rd(8'hC4, 32'h0);
    chk("irq", 32'h0, 32'(irq_ff));
    wr(8'hC4, 32'h1);
    rd(8'hC4, 32'h1);
    chk("irq", 32'h1, 32'(irq_ff));
    wr(8'hC0, 32'h1);
    rd(8'hC0, 32'h0);
    chk("irq", 32'h0, 32'(irq_ff));
    tally_and_finish;
  end
endmodule // tb
